// ### hw/gct_pkg.sv
package gct_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned ADR_W       = 6;
    localparam logic [5:0]  OFF_CLKCTL  = 6'h00;
    localparam logic [5:0]  OFF_MODE    = 6'h04;
    localparam logic [5:0]  OFF_TMRCTL  = 6'h08;
    localparam logic [5:0]  OFF_CNT0    = 6'h0c;
    localparam logic [5:0]  OFF_CNT1    = 6'h10;
    localparam logic [5:0]  OFF_CNT2    = 6'h14;
    localparam logic [5:0]  OFF_RLD2    = 6'h18;
    localparam logic [5:0]  OFF_CNT3    = 6'h1c;
    localparam logic [5:0]  OFF_RLD3    = 6'h20;
    localparam logic [5:0]  OFF_STATUS  = 6'h24;
    localparam logic [5:0]  OFF_MASK    = 6'h28;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned CLK_DIVSEL_LSB = 0;
    localparam int unsigned CLK_T0_SYS_BIT = 2;
    localparam int unsigned CLK_T2_SYS_BIT = 4;
    localparam int unsigned MODE_STRIDE    = 4;
    localparam int unsigned MODE_CT_BIT    = 2;
    localparam int unsigned MODE_GATE_BIT  = 3;
    localparam int unsigned CTL_RUN0_BIT   = 0;
    localparam int unsigned CTL_POL0_BIT   = 2;
    localparam int unsigned CTL_T2_BASE    = 4;
    localparam int unsigned CTL_T23_STRIDE = 5;
    localparam int unsigned CTL_RUN_OFS    = 0;
    localparam int unsigned CTL_SPLIT_OFS  = 1;
    localparam int unsigned CTL_CAP_OFS    = 2;
    localparam int unsigned CTL_XCLK_OFS   = 3;
    localparam int unsigned STAT_W         = 6;
    localparam int unsigned ST_TF0         = 0;
    localparam int unsigned ST_TF1         = 1;
    localparam int unsigned ST_T2_LO       = 2;
    localparam logic [15:0] RST_REG        = 16'h0000;

    // ------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------
    localparam int unsigned PRE_W       = 6;
    localparam int unsigned PRE_DIV [3] = '{12, 4, 48};
    localparam int unsigned EXT_DIV     = 8;
    localparam int unsigned NUM_SYNC    = 8;
    localparam int unsigned SY_EV0      = 0;
    localparam int unsigned SY_TMR_ZERO_PIN_GATING    = 2;
    localparam int unsigned SY_XOSC     = 4;
    localparam int unsigned SY_RTC      = 5;
    localparam int unsigned SY_CMP0     = 6;

    typedef enum logic [1:0] {
        MODE_13BIT   = 2'h0,
        MODE_16BIT   = 2'h1,
        MODE_RELOAD8 = 2'h2,
        MODE_SPLIT8  = 2'h3
    } gct_mode_e;

    typedef enum logic [1:0] {
        XCLK_DIV12 = 2'h0,
        XCLK_DIV8  = 2'h1,
        XCLK_CMP   = 2'h2,
        XCLK_RSVD  = 2'h3
    } gct_xclk_e;

endpackage

// ### hw/gct_edge_sync.sv
`timescale 1ns/1ps
module gct_edge_sync (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1Q, s2Q, s3Q;
    wire  agree = (s2Q == s3Q);

    // Level held at least two cycles always gives one agreeing pair
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1Q   <= 1'b0;
            s2Q   <= 1'b0;
            s3Q   <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end else begin
            s1Q   <= pin;
            s2Q   <= s1Q;
            s3Q   <= s2Q;
            level <= agree ? s3Q : level;
            rise  <= agree & s3Q & ~level;
            fall  <= agree & ~s3Q & level;
        end
    end

    a_fall_single: assert property (@(posedge mclk) disable iff (!reset_n) fall |=> !fall && !level)
        else $error("falling-edge pulse not single or level not low");
endmodule // gct_edge_sync

// ### hw/gct_reload_timer.sv
`timescale 1ns/1ps
module gct_reload_timer (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        tickLo,
    input  wire logic        tickHi,
    input  wire logic        run,
    input  wire logic        split,
    input  wire logic        capMode,
    input  wire logic        capEv,
    input  wire logic [1:0]  wrCnt,
    input  wire logic [1:0]  wrRld,
    input  wire logic [15:0] wdata,
    output logic      [15:0] cnt,
    output logic      [15:0] rld,
    output logic             ovfLo,
    output logic             ovfHi
);
    logic [15:0] cntD, rldD;
    wire  [15:0] inc16 = cnt + 16'h0001;
    wire  [7:0]  incLo = cnt[7:0] + 8'h01;
    wire  [7:0]  incHi = cnt[15:8] + 8'h01;

    always_comb begin
        cntD  = cnt;
        rldD  = rld;
        ovfLo = 1'b0;
        ovfHi = 1'b0;
        if (run && split) begin
            if (tickLo) begin
                ovfLo      = (cnt[7:0] == '1);
                cntD[7:0]  = ovfLo ? rld[7:0] : incLo;
            end
            if (tickHi) begin
                ovfHi      = (cnt[15:8] == '1);
                cntD[15:8] = ovfHi ? rld[15:8] : incHi;
            end
        end else if (run && tickLo) begin
            ovfHi = (cnt == '1);
            // Capture keeps the reload word as the measured value
            cntD  = (ovfHi && !capMode) ? rld : inc16;
        end
        if (capMode && !split && capEv) begin
            rldD  = cnt;
            ovfHi = 1'b1;
        end
        cntD[7:0]  = wrCnt[0] ? wdata[7:0]  : cntD[7:0];
        cntD[15:8] = wrCnt[1] ? wdata[15:8] : cntD[15:8];
        rldD[7:0]  = wrRld[0] ? wdata[7:0]  : rldD[7:0];
        rldD[15:8] = wrRld[1] ? wdata[15:8] : rldD[15:8];
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= gct_pkg::RST_REG;
            rld <= gct_pkg::RST_REG;
        end else begin
            cnt <= cntD;
            rld <= rldD;
        end
    end

    a_wrap_reload: assert property (@(posedge mclk) disable iff (!reset_n)
        run && !split && !capMode && tickLo && cnt == '1 && wrCnt == 2'h0 |=> cnt == $past(rld))
        else $error("16-bit auto-reload did not load reload value");
endmodule // gct_reload_timer

// ### hw/gct_timers.sv
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
module gct_timers (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        tmr_zero_event_pin,
    input  wire logic        tmr_one_event_pin,
    input  wire logic        tmr_zero_gating_input,
    input  wire logic        tmr_one_gating_input,
    input  wire logic        extOscClk,
    input  wire logic        rtcClk,
    input  wire logic        cmpZeroOut,
    input  wire logic        cmpOneOut,
    output logic             irq
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [7:0]  clkCtlQ, modeQ;
    logic [15:0] tmrCtlQ;
    logic [gct_pkg::STAT_W-1:0] statusQ, statusD, maskQ, maskD, events;
    logic [15:0] cnt01 [2];
    logic [15:0] cnt23 [2];
    logic [15:0] rld23 [2];
    logic [1:0]  ovf01, hiOvf01, ovf23Lo, ovf23Hi;

    wire busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wrEn     = busReq & wb_we_i;
    wire rdEn     = busReq & ~wb_we_i;
    wire hitClk   = (wb_adr_i == gct_pkg::OFF_CLKCTL);
    wire hitMode  = (wb_adr_i == gct_pkg::OFF_MODE);
    wire hitCtl   = (wb_adr_i == gct_pkg::OFF_TMRCTL);
    wire hitCnt0  = (wb_adr_i == gct_pkg::OFF_CNT0);
    wire hitCnt1  = (wb_adr_i == gct_pkg::OFF_CNT1);
    wire hitCnt2  = (wb_adr_i == gct_pkg::OFF_CNT2);
    wire hitRld2  = (wb_adr_i == gct_pkg::OFF_RLD2);
    wire hitCnt3  = (wb_adr_i == gct_pkg::OFF_CNT3);
    wire hitRld3  = (wb_adr_i == gct_pkg::OFF_RLD3);
    wire hitStat  = (wb_adr_i == gct_pkg::OFF_STATUS);
    wire hitMask  = (wb_adr_i == gct_pkg::OFF_MASK);
    wire rdStat   = rdEn & hitStat;
    wire [1:0] be = wb_sel_i[1:0];
    wire [1:0] wrCnt01 = {wrEn & hitCnt1, wrEn & hitCnt0};
    wire [1:0] wrCnt23 = {wrEn & hitCnt3, wrEn & hitCnt2};
    wire [1:0] wrRld23 = {wrEn & hitRld3, wrEn & hitRld2};

    // Unmapped addresses are acknowledged and read as zero
    wire [31:0] rdData =
        ({32{hitClk}}  & {24'h000000, clkCtlQ}) |
        ({32{hitMode}} & {24'h000000, modeQ}) |
        ({32{hitCtl}}  & {16'h0000, tmrCtlQ}) |
        ({32{hitCnt0}} & {16'h0000, cnt01[0]}) |
        ({32{hitCnt1}} & {16'h0000, cnt01[1]}) |
        ({32{hitCnt2}} & {16'h0000, cnt23[0]}) |
        ({32{hitRld2}} & {16'h0000, rld23[0]}) |
        ({32{hitCnt3}} & {16'h0000, cnt23[1]}) |
        ({32{hitRld3}} & {16'h0000, rld23[1]}) |
        ({32{hitStat}} & {26'h0000000, statusQ}) |
        ({32{hitMask}} & {26'h0000000, maskQ});

    // Hardware set wins over the clearing read in the same cycle
    assign statusD = (statusQ & ~{gct_pkg::STAT_W{rdStat}}) | events;
    assign maskD   = (wrEn & hitMask & be[0]) ? wb_dat_i[gct_pkg::STAT_W-1:0] : maskQ;
    assign events  = {ovf23Hi[1], ovf23Lo[1], ovf23Hi[0], ovf23Lo[0], ovf01[1] | hiOvf01[0], ovf01[0]};

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            clkCtlQ  <= gct_pkg::RST_REG[7:0];
            modeQ    <= gct_pkg::RST_REG[7:0];
            tmrCtlQ  <= gct_pkg::RST_REG;
            statusQ  <= '0;
            maskQ    <= '0;
            irq      <= 1'b0;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= rdEn ? rdData : wb_dat_o;
            clkCtlQ  <= (wrEn & hitClk & be[0]) ? wb_dat_i[7:0] : clkCtlQ;
            modeQ    <= (wrEn & hitMode & be[0]) ? wb_dat_i[7:0] : modeQ;
            tmrCtlQ[7:0]  <= (wrEn & hitCtl & be[0]) ? wb_dat_i[7:0] : tmrCtlQ[7:0];
            tmrCtlQ[15:8] <= (wrEn & hitCtl & be[1]) ? wb_dat_i[15:8] : tmrCtlQ[15:8];
            statusQ  <= statusD;
            maskQ    <= maskD;
            irq      <= |(statusD & maskD);
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers and clock sources
    // ------------------------------------------------------------
    wire [gct_pkg::NUM_SYNC-1:0] pins = {cmpOneOut, cmpZeroOut, rtcClk, extOscClk, tmr_one_gating_input,
                                         tmr_zero_gating_input, tmr_one_event_pin, tmr_zero_event_pin};
    logic [gct_pkg::NUM_SYNC-1:0] syLvl, syRise, syFall;
    logic [2:0] preTick;
    logic [1:0] div8Tick;

    for (genvar s = 0; s < gct_pkg::NUM_SYNC; s++) begin : g_sync
        gct_edge_sync u_sync (
            .mclk    (mclk),
            .reset_n (reset_n),
            .pin     (pins[s]),
            .level   (syLvl[s]),
            .rise    (syRise[s]),
            .fall    (syFall[s])
        );
    end

    // Prescalers are free-running strobes, never derived clocks
    for (genvar p = 0; p < 3; p++) begin : g_pre
        localparam logic [gct_pkg::PRE_W-1:0] LAST = gct_pkg::PRE_W'(gct_pkg::PRE_DIV[p] - 1);
        logic [gct_pkg::PRE_W-1:0] cQ;
        assign preTick[p] = (cQ == LAST);
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) cQ <= '0;
            else cQ <= preTick[p] ? '0 : cQ + 1'b1;
        end
    end

    // Index 0 divides the real-time clock, index 1 the external oscillator
    for (genvar d = 0; d < 2; d++) begin : g_div8
        localparam int unsigned SRC = (d == 0) ? gct_pkg::SY_RTC : gct_pkg::SY_XOSC;
        localparam logic [2:0]  LAST = 3'(gct_pkg::EXT_DIV - 1);
        logic [2:0] cQ;
        assign div8Tick[d] = syRise[SRC] & (cQ == LAST);
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) cQ <= '0;
            else if (syRise[SRC]) cQ <= cQ + 1'b1;
        end
    end

    wire [1:0] divSel = clkCtlQ[gct_pkg::CLK_DIVSEL_LSB +: 2];
    wire shareTick = (divSel == 2'h3) ? div8Tick[1] : preTick[divSel];

    // ------------------------------------------------------------
    // Timers 0 and 1
    // ------------------------------------------------------------
    wire run1 = tmrCtlQ[gct_pkg::CTL_RUN0_BIT + 1];

    // Classic pair here, the reload pair follows below
    for (genvar i = 0; i < 2; i++) begin : g_t01
        localparam int unsigned SH = i * gct_pkg::MODE_STRIDE;
        gct_pkg::gct_mode_e mode;
        logic [15:0] cntQ, cntD;
        logic        ovfLo, ovfHi;
        assign mode = gct_pkg::gct_mode_e'(modeQ[SH +: 2]);
        wire ctSel  = modeQ[SH + gct_pkg::MODE_CT_BIT];
        wire gate   = modeQ[SH + gct_pkg::MODE_GATE_BIT];
        wire runBit = tmrCtlQ[gct_pkg::CTL_RUN0_BIT + i];
        wire pol    = tmrCtlQ[gct_pkg::CTL_POL0_BIT + i];
        wire sysSel = clkCtlQ[gct_pkg::CLK_T0_SYS_BIT + i];
        wire timerTick = sysSel | shareTick;
        wire tick   = ctSel ? syFall[gct_pkg::SY_EV0 + i] : timerTick;
        wire allow  = runBit & (~gate | (syLvl[gct_pkg::SY_TMR_ZERO_PIN_GATING + i] == pol));
        // Timer 1 stands still while asked for the split mode it lacks
        wire enable = allow & tick & ~((i == 1) && (mode == gct_pkg::MODE_SPLIT8));
        wire hiTick = (i == 0) && (mode == gct_pkg::MODE_SPLIT8) && run1 && timerTick;
        wire [7:0]  lo  = cntQ[7:0];
        wire [7:0]  hi  = cntQ[15:8];
        wire [12:0] c13 = {hi, lo[4:0]} + 13'h0001;
        wire [15:0] c16 = cntQ + 16'h0001;

        always_comb begin
            cntD  = cntQ;
            ovfLo = 1'b0;
            ovfHi = 1'b0;
            if (enable) begin
                unique case (mode)
                    gct_pkg::MODE_13BIT: begin
                        cntD  = {c13[12:5], lo[7:5], c13[4:0]};
                        ovfLo = (c13 == '0);
                    end
                    gct_pkg::MODE_16BIT: begin
                        cntD  = c16;
                        ovfLo = (c16 == '0);
                    end
                    gct_pkg::MODE_RELOAD8: begin
                        ovfLo     = (lo == '1);
                        cntD[7:0] = ovfLo ? hi : lo + 8'h01;
                    end
                    gct_pkg::MODE_SPLIT8: begin
                        ovfLo     = (lo == '1);
                        cntD[7:0] = lo + 8'h01;
                    end
                endcase
            end
            if (hiTick) begin
                ovfHi      = (hi == '1);
                cntD[15:8] = hi + 8'h01;
            end
            cntD[7:0]  = (wrCnt01[i] & be[0]) ? wb_dat_i[7:0]  : cntD[7:0];
            cntD[15:8] = (wrCnt01[i] & be[1]) ? wb_dat_i[15:8] : cntD[15:8];
        end

        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) cntQ <= gct_pkg::RST_REG;
            else cntQ <= cntD;
        end

        assign cnt01[i]   = cntQ;
        assign ovf01[i]   = ovfLo;
        assign hiOvf01[i] = ovfHi;
    end

    // ------------------------------------------------------------
    // Timers 2 and 3
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_t23
        localparam int unsigned B = gct_pkg::CTL_T2_BASE + i * gct_pkg::CTL_T23_STRIDE;
        gct_pkg::gct_xclk_e xclk;
        assign xclk = gct_pkg::gct_xclk_e'(tmrCtlQ[B + gct_pkg::CTL_XCLK_OFS +: 2]);
        wire loSys = clkCtlQ[gct_pkg::CLK_T2_SYS_BIT + 2 * i];
        wire hiSys = clkCtlQ[gct_pkg::CLK_T2_SYS_BIT + 2 * i + 1];
        wire cmpEv = syRise[gct_pkg::SY_CMP0 + i];
        wire altTick = (xclk == gct_pkg::XCLK_DIV8) ? div8Tick[i] :
                       (xclk == gct_pkg::XCLK_CMP)  ? cmpEv : preTick[0];
        wire capEv = ((xclk == gct_pkg::XCLK_DIV8) & div8Tick[i]) |
                     ((xclk == gct_pkg::XCLK_CMP) & cmpEv);

        gct_reload_timer u_tmr (
            .mclk    (mclk),
            .reset_n (reset_n),
            .tickLo  (loSys | altTick),
            .tickHi  (hiSys | altTick),
            .run     (tmrCtlQ[B + gct_pkg::CTL_RUN_OFS]),
            .split   (tmrCtlQ[B + gct_pkg::CTL_SPLIT_OFS]),
            .capMode (tmrCtlQ[B + gct_pkg::CTL_CAP_OFS]),
            .capEv   (capEv),
            .wrCnt   ({2{wrCnt23[i]}} & be),
            .wrRld   ({2{wrRld23[i]}} & be),
            .wdata   (wb_dat_i[15:0]),
            .cnt     (cnt23[i]),
            .rld     (rld23[i]),
            .ovfLo   (ovf23Lo[i]),
            .ovfHi   (ovf23Hi[i])
        );
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_irq_level: assert property (irq == |(statusQ & maskQ))
        else $error("interrupt level disagrees with status and mask");
    a_read_clears: assert property (rdStat && events == '0 |=> statusQ == '0)
        else $error("status read did not clear flags");
    a_flag_sticky: assert property (statusQ[gct_pkg::ST_TF0] && !rdStat |=> statusQ[gct_pkg::ST_TF0])
        else $error("overflow flag dropped without a read");
    a_mode0_wrap: assert property (g_t01[1].enable && g_t01[1].mode == gct_pkg::MODE_13BIT
        && {cnt01[1][15:8], cnt01[1][4:0]} == '1 && !wrCnt01[1]
        |=> statusQ[gct_pkg::ST_TF1] && cnt01[1][15:8] == 8'h00 && cnt01[1][4:0] == 5'h00)
        else $error("13-bit rollover did not clear count and set flag");
    a_event_count: assert property (g_t01[0].ctSel && g_t01[0].allow && syFall[gct_pkg::SY_EV0]
        && g_t01[0].mode == gct_pkg::MODE_16BIT && !wrCnt01[0]
        |=> cnt01[0] == $past(cnt01[0]) + 16'h0001)
        else $error("event edge did not advance the count by one");
    a_reload_byte: assert property (g_t01[0].enable && g_t01[0].mode == gct_pkg::MODE_RELOAD8
        && cnt01[0][7:0] == '1 && !wrCnt01[0]
        |=> cnt01[0][7:0] == $past(cnt01[0][15:8]) && $stable(cnt01[0][15:8]))
        else $error("low byte not reloaded from unchanged high byte");
    a_run_hold: assert property (!g_t01[1].allow && !wrCnt01[1] |=> $stable(cnt01[1]))
        else $error("timer advanced while stopped or gated");
    a_pre_spacing: assert property (preTick[0] |=> !preTick[0] [*8])
        else $error("divide-by-12 strobe too frequent");
    a_div4_spacing: assert property (preTick[1] |=> !preTick[1] [*3])
        else $error("divide-by-4 strobe too frequent");
    a_ext_spacing: assert property (div8Tick[1] |=> !div8Tick[1] [*7])
        else $error("external divide-by-8 strobe too frequent");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");

    c_event_count: cover property (g_t01[0].ctSel && g_t01[0].enable);
    c_reload8: cover property (g_t01[1].mode == gct_pkg::MODE_RELOAD8 && ovf01[1]);
    c_irq_rise: cover property (!irq ##1 irq);
    c_split_t2: cover property (tmrCtlQ[gct_pkg::CTL_T2_BASE + gct_pkg::CTL_SPLIT_OFS] && ovf23Lo[0]);
    c_capture: cover property (g_t23[0].capEv && tmrCtlQ[gct_pkg::CTL_T2_BASE + gct_pkg::CTL_CAP_OFS]);
endmodule // gct_timers

// ### verification/gct_event_source.sv
`timescale 1ns/1ps
module gct_event_source (
    input  wire logic mclk,
    output logic      evZero,
    output logic      evOne,
    output logic      oscClk,
    output logic      rtcOsc
);
    int phase;
    initial begin
        evZero = 1'b1;
        evOne  = 1'b1;
        oscClk = 1'b0;
        rtcOsc = 1'b0;
        phase  = 0;
    end
    // Oscillators run free; each level lasts two or three cycles so the synchronisers see it
    always @(posedge mclk) begin
        phase  <= (phase == 5) ? 0 : phase + 1;
        oscClk <= (phase % 2 == 1) ? ~oscClk : oscClk;
        rtcOsc <= (phase == 2 || phase == 5) ? ~rtcOsc : rtcOsc;
    end
    // Each level held two cycles: a quarter of the system clock
    task automatic pulses(input logic sel, input int n);
        repeat (n) begin
            repeat (2) @(posedge mclk);
            if (sel) evOne <= 1'b0; else evZero <= 1'b0;
            repeat (2) @(posedge mclk);
            if (sel) evOne <= 1'b1; else evZero <= 1'b1;
        end
    endtask
endmodule // gct_event_source

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [31:0] v; logic [31:0] m; string nm;} gct_exp_s;
    logic        mclk, reset_n, wbCyc, wbStb, wbWe, gateZero, tieLow, irq, wbAck;
    logic [5:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatI, wbDatO;
    logic        evZero, evOne, oscClk, rtcOsc;
    gct_exp_s    expQ[$];
    gct_exp_s    e;
    int          miscompares, samples_checked, cycles, n;

    gct_event_source src (.mclk(mclk), .evZero(evZero), .evOne(evOne), .oscClk(oscClk), .rtcOsc(rtcOsc));
    gct_timers uut (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .tmr_zero_event_pin(evZero), .tmr_one_event_pin(evOne), .tmr_zero_gating_input(gateZero),
        .tmr_one_gating_input(tieLow), .extOscClk(oscClk), .rtcClk(rtcOsc), .cmpZeroOut(tieLow),
        .cmpOneOut(tieLow), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic busCycle(input logic we, input logic [5:0] adr, input logic [15:0] dat);
        @(posedge mclk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= adr;
        wbSel  <= 4'hf;
        wbDatI <= {16'h0000, dat};
        do @(posedge mclk); while (wbAck !== 1'b1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] adr, input logic [15:0] dat);
        busCycle(1'b1, adr, dat);
    endtask
    task automatic rd(input logic [5:0] adr, input logic [31:0] v, input logic [31:0] m, input string nm);
        expQ.push_back('{v, m, nm});
        busCycle(1'b0, adr, 16'h0000);
    endtask
    task automatic checkVal(input string nm, input logic [31:0] ex, input logic [31:0] seen);
        samples_checked++;
        if (seen !== ex) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic checkIrq(input logic ex);
        checkVal("irq", {31'h0, ex}, {31'h0, irq});
    endtask
    task automatic settle();
        repeat (8) @(posedge mclk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Read data is judged where the answer appears, against the oldest note
    always @(posedge mclk) begin
        if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
            e = expQ.pop_front();
            checkVal(e.nm, e.v & e.m, wbDatO & e.m);
        end
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {reset_n, wbCyc, wbStb, wbWe, gateZero, tieLow} = 6'h00;
        wbAdr = 6'h00; wbSel = 4'h0; wbDatI = 32'h0;
        n = $urandom(29405);
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd(gct_pkg::OFF_CLKCTL, 32'h0, 32'hffff, "clkctl");
        rd(6'h2c, 32'h0, 32'hffffffff, "unmapped");
        wr(gct_pkg::OFF_MASK, 16'h0003);
        wr(gct_pkg::OFF_MODE, 16'h004d);
        wr(gct_pkg::OFF_CNT1, 16'hff1e);
        wr(gct_pkg::OFF_TMRCTL, 16'h0007);
        src.pulses(1'b0, 2);
        settle();
        rd(gct_pkg::OFF_CNT0, 32'h0, 32'hffff, "gated cnt0");
        gateZero <= 1'b1;
        repeat (4) @(posedge mclk);
        n = $urandom_range(8, 1);
        src.pulses(1'b0, n);
        settle();
        rd(gct_pkg::OFF_CNT0, n, 32'hffff, "event cnt0");
        src.pulses(1'b1, 3);
        settle();
        rd(gct_pkg::OFF_CNT1, 32'h0001, 32'hff1f, "wrap cnt1");
        checkIrq(1'b1);
        rd(gct_pkg::OFF_STATUS, 32'h02, 32'h3f, "status");
        checkIrq(1'b0);
        wr(gct_pkg::OFF_MASK, 16'h0000);
        wr(gct_pkg::OFF_MODE, 16'h0046);
        wr(gct_pkg::OFF_CNT0, 16'h80fe);
        src.pulses(1'b0, 3);
        settle();
        checkIrq(1'b0);
        rd(gct_pkg::OFF_CNT0, 32'h8081, 32'hffff, "reload cnt0");
        rd(gct_pkg::OFF_STATUS, 32'h01, 32'h3f, "status");
        wr(gct_pkg::OFF_RLD2, 16'h1230);
        wr(gct_pkg::OFF_CNT2, 16'hffff);
        wr(gct_pkg::OFF_RLD3, 16'h4560);
        wr(gct_pkg::OFF_CNT3, 16'hffff);
        wr(gct_pkg::OFF_TMRCTL, 16'h1297);
        repeat (100) @(posedge mclk);
        rd(gct_pkg::OFF_CNT2, 32'h1230, 32'hfff0, "alt cnt2");
        rd(gct_pkg::OFF_CNT3, 32'h4560, 32'hfff0, "alt cnt3");
        rd(gct_pkg::OFF_STATUS, 32'h28, 32'h3f, "status");
        wr(gct_pkg::OFF_CLKCTL, 16'h0031);
        wr(gct_pkg::OFF_MODE, 16'h0042);
        wr(gct_pkg::OFF_CNT0, 16'hfefe);
        wr(gct_pkg::OFF_RLD2, 16'hf0f0);
        wr(gct_pkg::OFF_CNT2, 16'hf0f0);
        wr(gct_pkg::OFF_TMRCTL, 16'h0037);
        repeat (40) @(posedge mclk);
        rd(gct_pkg::OFF_CNT0, 32'hfefe, 32'hfffe, "prescaled cnt0");
        rd(gct_pkg::OFF_CNT2, 32'hf0f0, 32'hf0f0, "split cnt2");
        rd(gct_pkg::OFF_STATUS, 32'h0d, 32'h3f, "status");
        end_of_test();
    end
endmodule // testbench
